// ===== rtl/uc_core.sv
`timescale 1ns/1ps
`default_nettype none
module uc_core #(
    parameter int DEPTH = uc_pkg::RX_DEPTH,
    parameter logic [15:0] DIV_RESET = 16'(uc_pkg::DIV_DEFAULT)
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [uc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [uc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [uc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic serial_in_line,
    output logic serial_out_line,
    output logic rx_char_available,
    output logic rx_fifo_full,
    output logic irq_req
);
    import uc_pkg::*;

    localparam int PW = $clog2(DEPTH + 1);

    // Register decode
    wire wr_data = reg_wr && (reg_addr == ADDR_DATA);
    wire rd_data = reg_rd && (reg_addr == ADDR_DATA);
    wire wr_mode = reg_wr && (reg_addr == ADDR_MODE);
    wire wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
    wire wr_imask = reg_wr && (reg_addr == ADDR_IMASK);
    wire wr_istat = reg_wr && (reg_addr == ADDR_ISTAT);
    wire wr_div_lo = reg_wr && (reg_addr == ADDR_DIV_LO);
    wire wr_div_hi = reg_wr && (reg_addr == ADDR_DIV_HI);
    wire err_clr = wr_ctrl && reg_wdata[CTRL_ERR_CLR];

    logic [7:0] mode_reg_one;
    logic [7:0] irq_mask_reg;
    logic [15:0] baud_div;
    logic tx_en;
    logic rx_en;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mode_reg_one <= MODE_RST;
            irq_mask_reg <= '0;
            baud_div <= DIV_RESET;
            tx_en <= 1'b0;
            rx_en <= 1'b0;
        end else begin
            if (wr_mode) mode_reg_one <= reg_wdata;
            if (wr_imask) irq_mask_reg <= reg_wdata;
            if (wr_div_lo) baud_div[7:0] <= reg_wdata;
            if (wr_div_hi) baud_div[15:8] <= reg_wdata;
            if (wr_ctrl) begin
                tx_en <= reg_wdata[CTRL_TX_EN];
                rx_en <= reg_wdata[CTRL_RX_EN];
            end
        end
    end

    // 16x oversampling tick
    logic [15:0] div_cnt;
    wire os_tick = (div_cnt >= baud_div);

    always_ff @(posedge core_clk) begin
        if (sys_rst || os_tick) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 16'h1;
        end
    end

    // Character format
    wire [1:0] par_mode = mode_reg_one[MODE_PAR_HI:MODE_PAR_LO];
    wire par_on = (par_mode != PAR_NONE);
    wire par_type = mode_reg_one[MODE_PAR_TYPE];
    wire [2:0] last_bit = LAST_BIT_BASE
        + {1'b0, mode_reg_one[MODE_LEN_HI:MODE_LEN_LO]};
    wire [7:0] len_mask = ALL_ONES >> (BIT_IDX_MAX - last_bit);

    function automatic logic par_of(input logic [7:0] d);
        par_of = (par_mode == PAR_WITH) ? (^d ^ par_type) : par_type;
    endfunction : par_of

    // Transmitter
    uc_tx_state_t tx_state;
    logic hold_valid;
    logic [7:0] hold_data;
    logic [7:0] tx_shift;
    logic [2:0] tx_bit;
    logic [3:0] tx_os;
    logic tx_par;

    wire tx_accept = wr_data && tx_en && !hold_valid;
    wire tx_bit_end = os_tick && (tx_os == OS_LAST);
    wire tx_last = (tx_bit == last_bit);
    wire tx_load = hold_valid && ((tx_state == TX_IDLE)
        || ((tx_state == TX_STOP) && tx_bit_end));
    wire tx_empty = !hold_valid && (tx_state == TX_IDLE);
    wire tx_ready = tx_en && !hold_valid;
    wire [7:0] hold_masked = hold_data & len_mask;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            hold_valid <= 1'b0;
            hold_data <= '0;
        end else if (tx_accept) begin
            hold_valid <= 1'b1;
            hold_data <= reg_wdata;
        end else if (tx_load) begin
            hold_valid <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            tx_state <= TX_IDLE;
            serial_out_line <= 1'b1;
            tx_shift <= '0;
            tx_bit <= '0;
            tx_os <= OS_ZERO;
            tx_par <= 1'b0;
        end else if (tx_load) begin
            tx_state <= TX_START;
            serial_out_line <= 1'b0;
            tx_shift <= hold_masked;
            tx_par <= par_of(hold_masked);
            tx_bit <= '0;
            tx_os <= OS_ZERO;
        end else begin
            if (os_tick && (tx_state != TX_IDLE)) tx_os <= tx_os + 4'h1;
            if (tx_bit_end) begin
                case (tx_state)
                    TX_START: begin
                        tx_state <= TX_DATA;
                        serial_out_line <= tx_shift[0];
                    end
                    TX_DATA: begin
                        if (tx_last) begin
                            tx_state <= par_on ? TX_PARITY : TX_STOP;
                            serial_out_line <= par_on ? tx_par : 1'b1;
                        end else begin
                            tx_bit <= tx_bit + 3'h1;
                            tx_shift <= tx_shift >> 1;
                            serial_out_line <= tx_shift[1];
                        end
                    end
                    TX_PARITY: begin
                        tx_state <= TX_STOP;
                        serial_out_line <= 1'b1;
                    end
                    default: begin
                        tx_state <= TX_IDLE;
                        serial_out_line <= 1'b1;
                    end
                endcase
            end
        end
    end

    // Receiver
    uc_rx_state_t rx_state;
    logic [3:0] rx_os;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_any_one;
    logic rx_perr;
    logic rx_done;
    logic [FIFO_W-1:0] rx_word;
    logic brk_delta;

    wire rx_sample = os_tick && (rx_os == OS_LAST);
    wire rx_cell = (rx_state == RX_DATA) || (rx_state == RX_PARITY)
        || (rx_state == RX_STOP);
    wire rx_last = (rx_bit == last_bit);
    wire rx_par_bad = par_on && (serial_in_line != par_of(rx_shift));
    wire brk_start = (rx_state == RX_STOP) && rx_sample
        && !serial_in_line && !rx_any_one;
    wire brk_end = (rx_state == RX_BREAK) && os_tick && serial_in_line;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rx_state <= RX_IDLE;
            rx_os <= OS_ZERO;
            rx_bit <= '0;
            rx_shift <= '0;
            rx_any_one <= 1'b0;
            rx_perr <= 1'b0;
            rx_done <= 1'b0;
            rx_word <= '0;
        end else begin
            rx_done <= 1'b0;
            if (os_tick && rx_cell) rx_os <= rx_os + 4'h1;
            case (rx_state)
                RX_IDLE: begin
                    if (os_tick && rx_en && !serial_in_line) begin
                        rx_state <= RX_START;
                        rx_os <= START_FIRST;
                        rx_bit <= '0;
                        rx_shift <= '0;
                        rx_any_one <= 1'b0;
                        rx_perr <= 1'b0;
                    end
                end
                RX_START: begin
                    if (os_tick) begin
                        if (rx_os == START_LAST) begin
                            rx_state <= serial_in_line ? RX_IDLE : RX_DATA;
                            rx_os <= OS_ZERO;
                        end else begin
                            rx_os <= rx_os + 4'h1;
                        end
                    end
                end
                RX_DATA: begin
                    if (rx_sample) begin
                        rx_shift[rx_bit] <= serial_in_line;
                        rx_any_one <= rx_any_one | serial_in_line;
                        rx_bit <= rx_bit + 3'h1;
                        if (rx_last) begin
                            rx_state <= par_on ? RX_PARITY : RX_STOP;
                        end
                    end
                end
                RX_PARITY: begin
                    if (rx_sample) begin
                        rx_perr <= rx_par_bad;
                        rx_any_one <= rx_any_one | serial_in_line;
                        rx_state <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_sample) begin
                        rx_done <= 1'b1;
                        rx_state <= RX_IDLE;
                        rx_word <= '0;
                        if (serial_in_line) begin
                            rx_word[FL_PE] <= rx_perr;
                            rx_word[7:0] <= rx_shift;
                        end else if (!rx_any_one) begin
                            rx_word[FL_BRK] <= 1'b1;
                            rx_state <= RX_BREAK;
                        end else begin
                            rx_word[FL_FE] <= 1'b1;
                            rx_word[FL_PE] <= rx_perr;
                            rx_word[7:0] <= rx_shift;
                        end
                    end
                end
                default: begin
                    if (brk_end) rx_state <= RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            brk_delta <= 1'b0;
        end else if (brk_start || brk_end) begin
            brk_delta <= 1'b1;
        end else if (wr_istat && reg_wdata[IRQ_BRK]) begin
            brk_delta <= 1'b0;
        end
    end

    // Receive FIFO with the shift stage as a waiting slot
    logic [FIFO_W-1:0] fifo_mem [DEPTH];
    logic [PW-1:0] rd_ptr;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] fifo_cnt;
    logic rsr_full;
    logic [FIFO_W-1:0] rsr_word;
    logic overrun_flag;

    wire avail = (fifo_cnt != '0);
    wire full = (fifo_cnt == PW'(DEPTH));
    wire pop = rd_data && avail;
    wire push_req = rsr_full || rx_done;
    wire push = push_req && (!full || pop);
    wire [FIFO_W-1:0] push_word = rsr_full ? rsr_word : rx_word;
    wire [FIFO_W-1:0] fifo_top = fifo_mem[rd_ptr];
    wire overrun = rx_done && rsr_full && !push;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction : ptr_inc

    always_ff @(posedge core_clk) begin
        if (push) fifo_mem[wr_ptr] <= push_word;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            fifo_cnt <= '0;
        end else begin
            if (push) wr_ptr <= ptr_inc(wr_ptr);
            if (pop) rd_ptr <= ptr_inc(rd_ptr);
            if (push && !pop) begin
                fifo_cnt <= fifo_cnt + PW'(1);
            end else if (pop && !push) begin
                fifo_cnt <= fifo_cnt - PW'(1);
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            rsr_full <= 1'b0;
            rsr_word <= '0;
        end else if (rx_done) begin
            if (!(push && !rsr_full)) begin
                rsr_full <= 1'b1;
                rsr_word <= rx_word;
            end
        end else if (push) begin
            rsr_full <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            overrun_flag <= 1'b0;
        end else if (overrun) begin
            overrun_flag <= 1'b1;
        end else if (err_clr) begin
            overrun_flag <= 1'b0;
        end
    end

    // Status and interrupt views
    logic [7:0] channel_status_reg;
    logic [7:0] irq_status_reg;

    always_comb begin
        channel_status_reg = '0;
        channel_status_reg[ST_AVAIL] = avail;
        channel_status_reg[ST_FULL] = full;
        channel_status_reg[ST_TX_READY] = tx_ready;
        channel_status_reg[ST_TX_EMPTY] = tx_empty;
        channel_status_reg[ST_OVERRUN] = overrun_flag;
        channel_status_reg[ST_PARITY] = avail && fifo_top[FL_PE];
        channel_status_reg[ST_FRAME] = avail && fifo_top[FL_FE];
        channel_status_reg[ST_BREAK] = avail && fifo_top[FL_BRK];
    end

    always_comb begin
        irq_status_reg = '0;
        irq_status_reg[IRQ_TX] = tx_empty;
        irq_status_reg[IRQ_RX] = mode_reg_one[MODE_RX_IRQ_SEL] ? full : avail;
        irq_status_reg[IRQ_BRK] = brk_delta;
    end

    assign irq_req = |(irq_status_reg & irq_mask_reg);
    assign rx_char_available = avail;
    assign rx_fifo_full = full;

    // Read path
    logic [7:0] rd_mux;
    wire [7:0] ctrl_view = {6'h00, rx_en, tx_en};

    always_comb begin
        if (reg_addr == ADDR_DATA) begin
            rd_mux = avail ? fifo_top[7:0] : '0;
        end else if (reg_addr == ADDR_STATUS) begin
            rd_mux = channel_status_reg;
        end else if (reg_addr == ADDR_MODE) begin
            rd_mux = mode_reg_one;
        end else if (reg_addr == ADDR_CTRL) begin
            rd_mux = ctrl_view;
        end else if (reg_addr == ADDR_IMASK) begin
            rd_mux = irq_mask_reg;
        end else if (reg_addr == ADDR_ISTAT) begin
            rd_mux = irq_status_reg;
        end else if (reg_addr == ADDR_DIV_LO) begin
            rd_mux = baud_div[7:0];
        end else begin
            rd_mux = baud_div[15:8];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    a_tx_idle_mark: assert property (
        (tx_state == TX_IDLE) |-> serial_out_line)
        else $error("line not marking while idle");
    a_tx_start_low: assert property (
        tx_load |=> !serial_out_line && (tx_state == TX_START))
        else $error("start bit missing");
    a_tx_lsb_first: assert property (
        (tx_state == TX_START) && tx_bit_end
        |=> serial_out_line == $past(tx_shift[0]))
        else $error("first data bit is not the lsb");
    a_tx_parity_slot: assert property (
        (tx_state == TX_DATA) && tx_bit_end && tx_last && par_on
        |=> (tx_state == TX_PARITY) && serial_out_line == $past(tx_par))
        else $error("parity bit not after last data bit");
    a_tx_refuse_off: assert property (
        wr_data && !tx_en && !hold_valid |=> !hold_valid)
        else $error("write taken while transmitter off");
    a_tx_irq_empty: assert property (
        irq_mask_reg[IRQ_TX] && tx_empty |-> irq_req)
        else $error("transmit interrupt missing");
    a_rx_noise_drop: assert property (
        (rx_state == RX_START) && os_tick && (rx_os == START_LAST)
        && serial_in_line |=> rx_state == RX_IDLE)
        else $error("noise pulse taken as start");
    a_rx_overrun_set: assert property (
        overrun |=> overrun_flag && rsr_full)
        else $error("overrun not flagged");
    a_rx_break_flag: assert property (
        brk_start |=> (rx_state == RX_BREAK) && brk_delta && rx_done)
        else $error("break not handled");
    a_rx_last_pop: assert property (
        pop && (fifo_cnt == PW'(1)) && !push |=> !rx_char_available)
        else $error("ready stays after last read");

    c_tx_char: cover property ((tx_state == TX_STOP) ##1 tx_load);
    c_rx_break: cover property (brk_start ##[1:1000] brk_end);
    c_rx_overrun: cover property (overrun);
    c_rx_parity: cover property (rx_done && rx_word[FL_PE]);
endmodule : uc_core
`default_nettype wire

// ===== inc/uc_pkg.sv
package uc_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_STATUS = 3'h1;
    localparam logic [2:0] ADDR_MODE = 3'h2;
    localparam logic [2:0] ADDR_CTRL = 3'h3;
    localparam logic [2:0] ADDR_IMASK = 3'h4;
    localparam logic [2:0] ADDR_ISTAT = 3'h5;
    localparam logic [2:0] ADDR_DIV_LO = 3'h6;
    localparam logic [2:0] ADDR_DIV_HI = 3'h7;
    // Channel status bits
    localparam int ST_AVAIL = 0;
    localparam int ST_FULL = 1;
    localparam int ST_TX_READY = 2;
    localparam int ST_TX_EMPTY = 3;
    localparam int ST_OVERRUN = 4;
    localparam int ST_PARITY = 5;
    localparam int ST_FRAME = 6;
    localparam int ST_BREAK = 7;
    // Mode register fields
    localparam int MODE_LEN_LO = 0;
    localparam int MODE_LEN_HI = 1;
    localparam int MODE_PAR_TYPE = 2;
    localparam int MODE_PAR_LO = 3;
    localparam int MODE_PAR_HI = 4;
    localparam int MODE_RX_IRQ_SEL = 6;
    localparam logic [1:0] PAR_WITH = 2'h0;
    localparam logic [1:0] PAR_FORCE = 2'h1;
    localparam logic [1:0] PAR_NONE = 2'h2;
    localparam logic [1:0] PAR_DROP = 2'h3;
    localparam logic [7:0] MODE_RST = 8'h13;
    // Control and interrupt bits
    localparam int CTRL_TX_EN = 0;
    localparam int CTRL_RX_EN = 1;
    localparam int CTRL_ERR_CLR = 2;
    localparam int IRQ_TX = 0;
    localparam int IRQ_RX = 1;
    localparam int IRQ_BRK = 2;
    // Receive word layout in the FIFO
    localparam int FIFO_W = 11;
    localparam int FL_PE = 8;
    localparam int FL_FE = 9;
    localparam int FL_BRK = 10;
    // Timing
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] OS_ZERO = 4'h0;
    localparam logic [3:0] OS_LAST = 4'hF;
    localparam logic [3:0] START_FIRST = 4'h1;
    localparam logic [3:0] START_LAST = 4'h6;
    localparam logic [2:0] LAST_BIT_BASE = 3'h4;
    localparam logic [2:0] BIT_IDX_MAX = 3'h7;
    localparam logic [7:0] ALL_ONES = 8'hFF;
    localparam int RX_DEPTH = 3;
    localparam int CLK_HZ = 100_000_000;
    localparam int BAUD_DEFAULT = 9600;
    localparam int DIV_DEFAULT = CLK_HZ / (OVERSAMPLE * BAUD_DEFAULT) - 1;
    typedef enum logic [4:0] {
        TX_IDLE = 5'h01,
        TX_START = 5'h02,
        TX_DATA = 5'h04,
        TX_PARITY = 5'h08,
        TX_STOP = 5'h10
    } uc_tx_state_t;
    typedef enum logic [5:0] {
        RX_IDLE = 6'h01,
        RX_START = 6'h02,
        RX_DATA = 6'h04,
        RX_PARITY = 6'h08,
        RX_STOP = 6'h10,
        RX_BREAK = 6'h20
    } uc_rx_state_t;
endpackage : uc_pkg

// ===== test/uc_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module uc_far_end (
    input wire logic core_clk,
    input wire logic serial_out_line,
    output logic serial_in_line,
    output logic [8:0] got,
    output logic got_stb
);
    initial begin
        serial_in_line = 1'b1;
        got = 9'h000;
        got_stb = 1'b0;
    end
    task automatic drive(input logic [31:0] bits, input int n, input int len);
        for (int i = 0; i < n; i++) begin
            serial_in_line <= bits[i];
            repeat (len) @(posedge core_clk);
        end
    endtask : drive
    // Mid-cell sampling of nine cells
    always begin
        @(negedge serial_out_line);
        repeat (8) @(posedge core_clk);
        for (int i = 0; i < 9; i++) begin
            repeat (16) @(posedge core_clk);
            got[i] <= serial_out_line;
        end
        got_stb <= 1'b1;
        @(posedge core_clk);
        got_stb <= 1'b0;
    end
endmodule : uc_far_end
`default_nettype wire

// ===== test/uc_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module uc_core_tb;
    import uc_pkg::*;
    logic core_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, m, d;
    logic serial_in_line, serial_out_line, rx_char_available;
    logic rx_fifo_full, irq_req, got_stb, rd_d = 1'b0;
    logic [8:0] got;
    logic [15:0] f;
    logic [7:0] rc [5];
    logic [7:0] rd_q [$];
    logic [15:0] tx_q [$];
    int bad_count = 0, n_checks = 0;
    always #5 core_clk = ~core_clk;
    uc_core #(.DIV_RESET(16'h0000)) dut (.core_clk(core_clk),
        .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
        .rx_char_available(rx_char_available), .rx_fifo_full(rx_fifo_full),
        .irq_req(irq_req));
    uc_far_end peer (.core_clk(core_clk), .serial_out_line(serial_out_line),
        .serial_in_line(serial_in_line), .got(got), .got_stb(got_stb));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : give_verdict
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        tick(1);
        reg_wr <= 1'b0;
        tick(1);
    endtask : wr
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        tick(1);
        reg_rd <= 1'b0;
        tick(1);
    endtask : rd
    // Data, parity and stop bits of a frame, idle ones above
    function automatic logic [15:0] frm(logic [7:0] md, logic [7:0] v);
        int n;
        logic [15:0] r;
        n = 5 + md[1:0];
        r = (16'hFFFF << n) | 16'(v & ~(ALL_ONES << n));
        if (md[4:3] != PAR_NONE)
            r[n] = md[4:3] == PAR_WITH
                ? ^(r[7:0] & ~(ALL_ONES << n)) ^ md[2] : md[2];
        return r;
    endfunction : frm
    task automatic send(input logic [15:0] fr);
        peer.drive(32'({fr, 1'b0}), 12, 16);
    endtask : send
    always @(posedge core_clk) begin
        rd_d <= reg_rd;
        if (rd_d === 1'b1)
            check(16'(reg_rdata), rd_q.size() ? 16'(rd_q.pop_front()) : 16'hFFFF);
        if (got_stb === 1'b1)
            check(16'(got), tx_q.size() ? tx_q.pop_front() : 16'hFFFF);
    end
    initial begin
        tick(90000);
        bad_count++;
        give_verdict();
    end
    initial begin
        void'($urandom(65));
        tick(16);
        sys_rst <= 1'b0;
        tick(1);
        check(16'(serial_out_line), 16'h1);
        rd(ADDR_MODE, MODE_RST);
        wr(ADDR_CTRL, 8'h01);
        for (int i = 0; i < 32; i++) begin
            m = {3'h0, 2'(i / 8), 1'((i / 4) % 2), 2'(i % 4)};
            d = 8'($urandom);
            tx_q.push_back(frm(m, d) & 16'h01FF);
            wr(ADDR_MODE, m);
            wr(ADDR_DATA, d);
            tick(200);
        end
        wr(ADDR_MODE, 8'h13);
        wr(ADDR_IMASK, 8'h01);
        for (int i = 0; i < 2; i++) begin
            d = 8'($urandom);
            tx_q.push_back(frm(8'h13, d) & 16'h01FF);
            wr(ADDR_DATA, d);
            tick(3);
        end
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_DATA, 8'hA5);
        rd(ADDR_STATUS, 8'h00);
        check(16'(irq_req), 16'h0);
        tick(400);
        check(16'(irq_req), 16'h1);
        wr(ADDR_DATA, 8'h5A);
        check(16'(irq_req), 16'h1);
        wr(ADDR_CTRL, 8'h02);
        wr(ADDR_IMASK, 8'h02);
        wr(ADDR_MODE, 8'h53);
        for (int i = 0; i < 5; i++) begin
            rc[i] = 8'($urandom);
            send(frm(8'h53, rc[i]));
            if (i == 0) check(16'(irq_req), 16'h0);
            if (i == 0) check(16'(rx_char_available), 16'h1);
            if (i == 2) check(16'(rx_fifo_full), 16'h1);
            if (i == 2) check(16'(irq_req), 16'h1);
        end
        rd(ADDR_STATUS, 8'h1B);
        for (int i = 0; i < 4; i++) rd(ADDR_DATA, rc[i == 3 ? 4 : i]);
        check(16'(rx_char_available), 16'h0);
        wr(ADDR_CTRL, 8'h06);
        wr(ADDR_MODE, 8'h03);
        d = 8'($urandom) | 8'h01;
        f = frm(8'h03, d);
        f[8] = ~f[8];
        send(f);
        rd(ADDR_STATUS, 8'h29);
        rd(ADDR_DATA, d);
        f[8] = ~f[8];
        // Short low stop cell, so its tail is rejected as noise
        peer.drive(32'({f, 1'b0}), 10, 16);
        peer.drive(32'h2, 2, 8);
        rd(ADDR_STATUS, 8'h49);
        rd(ADDR_DATA, d);
        wr(ADDR_ISTAT, 8'h04);
        peer.drive(32'h0, 30, 16);
        rd(ADDR_STATUS, 8'h89);
        wr(ADDR_ISTAT, 8'h04);
        rd(ADDR_ISTAT, 8'h03);
        peer.drive(32'h1, 1, 16);
        rd(ADDR_ISTAT, 8'h07);
        rd(ADDR_DATA, 8'h00);
        check(16'(rx_char_available), 16'h0);
        peer.drive(32'h2, 2, 3);
        tick(300);
        check(16'(rx_char_available), 16'h0);
        check(16'(tx_q.size()), 16'h0);
        give_verdict();
    end
endmodule : uc_core_tb
`default_nettype wire
